// ===== bench/vectored_irq_controller_tb.sv
`timescale 1ns/100ps
module vectored_irq_controller_tb;
  import vicx_pkg::*;
  logic clk = 0, srst = 1, wr = 0, rd = 0, bwr = 0, bval = 0, slow = 0;
  logic x0 = 1, x1 = 1, t0 = 0, t1 = 0, up = 0, t2l = 0, t2h = 0, sp = 0;
  logic le = 0, lc = 0, len = 0, idn = 0, rti = 0, ack, req, lin;
  logic [7:0] addr = 0, wd = 0, ba = 0, hp = 0, rdat, v;
  logic [3:0] af, fs = 0, fc = 0;
  logic [15:0] vec;
  logic [1:0] srv;
  int fails = 0, comparisons = 0;
  always #5 clk = ~clk;
  vicx_irq_ctrl u_dut (.i_clk_sys(clk), .i_srst(srst), .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_wdata(wd), .i_sfr_rd(rd), .i_sfr_bit_wr(bwr),
    .i_sfr_bit_addr(ba), .i_sfr_bit_val(bval), .o_sfr_rdata(rdat),
    .i_ext_input_zero(x0), .i_ext_input_one(x1),
    .i_timer0_overflow_flag(t0), .i_timer1_overflow_flag(t1),
    .i_auto_flag_set(fs), .i_auto_flag_clr(fc), .o_auto_flags(af),
    .i_uart_pending(up), .i_timer2_low_overflow_flag(t2l),
    .i_timer2_high_overflow_flag(t2h), .i_spi_pending(sp),
    .i_lin_event(le), .i_lin_flag_clear_ctl(lc), .i_lin_irq_en(len),
    .o_lin_pending_flag(lin), .i_slot_high_prio(hp), .i_instr_done(idn),
    .i_reti_done(rti), .i_call_ack(ack), .o_call_req(req),
    .o_call_vector(vec), .o_in_service(srv));
  vicx_core_model u_core (.i_clk_sys(clk), .i_srst(srst),
    .i_call_req(req), .i_slow(slow), .o_call_ack(ack));
  task automatic cyc(input int n); repeat (n) @(negedge clk); endtask
  task automatic chk(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, d);
    addr = a; wd = d; wr = 1; cyc(1); wr = 0;
  endtask
  task automatic bset(input logic [7:0] a, input logic b);
    ba = a; bval = b; bwr = 1; cyc(1); bwr = 0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    addr = a; rd = 1; cyc(1); rd = 0; d = rdat;
  endtask
  task automatic wait_req(input logic e);
    for (int i = 0; i < 30 && req !== e; i++) cyc(1);
    if (req !== e) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic end_isr;
    rti = 1; cyc(1); rti = 0; idn = 1; cyc(1); idn = 0; cyc(2);
  endtask
  initial begin
    cyc(10); srst = 0; cyc(3);
    rreg(IRQ_ENABLE_MAIN_ADDR, v); chk("ie_reset", v, 0);
    cyc(1); rreg(8'ha9, v); chk("unmapped", v, 0);
    wreg(8'ha8, 8'h10); up = 1; cyc(4); chk("gate_off", req, 0);
    bset(8'haf, 1); rreg(8'ha8, v); chk("bit_wr", v, 8'h90);
    wait_req(1); chk("uart_vec", vec, 16'h0023);
    wait_req(0); chk("srv_lo", srv, 2'h1);
    rti = 1; cyc(1); rti = 0; cyc(3); chk("hold", req, 0);
    idn = 1; cyc(1); idn = 0; cyc(1); chk("reenter", req, 1);
    up = 0; wait_req(0); end_isr;
    wreg(8'ha8, 8'ha0); t2h = 1; cyc(1); chk("t2_lat", req, 1);
    chk("t2_vec", vec, 16'h002b); t2h = 0; cyc(2); end_isr;
    slow = 1; wreg(8'ha8, 8'h8a); t0 = 1; t1 = 1; cyc(1); t0 = 0; t1 = 0;
    chk("flags", af, 4'ha);
    wait_req(1); chk("order", vec, 16'h000b);
    wait_req(0); chk("t0_clr", af, 4'h8); end_isr;
    wait_req(1); chk("t1_vec", vec, 16'h001b);
    wait_req(0); chk("t1_clr", af, 4'h0); end_isr;
    slow = 0; wreg(8'ha8, 8'h81); x0 = 0;
    wait_req(1); chk("pin_vec", vec, VEC_FIRST);
    wait_req(0); x0 = 1; end_isr;
    wreg(8'ha8, 8'h80); le = 1; cyc(1); le = 0;
    chk("lin_set", lin, 1); chk("lin_off", req, 0);
    len = 1; wait_req(1); chk("lin_vec", vec, VEC_LIN);
    wait_req(0); chk("lin_keep", lin, 1);
    lc = 1; cyc(1); lc = 0; len = 0; chk("lin_clr", lin, 0); end_isr;
    hp = 8'h10; wreg(8'ha8, 8'h98); t1 = 1; cyc(1); t1 = 0;
    wait_req(1); wait_req(0); up = 1;
    wait_req(1); chk("preempt", vec, 16'h0023);
    wait_req(0); chk("srv_both", srv, 2'h3);
    up = 0; end_isr; chk("srv_back", srv, 2'h1); end_isr;
    wreg(8'ha8, 8'hc0); sp = 1; rti = 1; cyc(1); rti = 0; cyc(7);
    chk("div_wait", req, 0);
    idn = 1; cyc(1); idn = 0; cyc(1); chk("div_done", req, 1);
    chk("spi_vec", vec, 16'h0033); wait_req(0); sp = 0; end_isr;
    wreg(8'ha8, 8'ha0); t2l = 1; wait_req(1);
    chk("t2l_vec", vec, 16'h002b);
    wait_req(0); t2l = 0; end_isr;
    wreg(8'ha8, 8'h84); x1 = 0; wait_req(1);
    chk("pin1_vec", vec, 16'h0013);
    wait_req(0); chk("pin1_clr", af, 4'h0); x1 = 1; end_isr;
    wreg(8'ha8, 8'h00); fs = 4'h4; fc = 4'h4; cyc(1); fs = 0;
    chk("set_wins", af, 4'h4); cyc(1); fc = 0; chk("sw_clr", af, 4'h0);
    tally_and_finish();
  end
endmodule // vectored_irq_controller_tb

// ===== bench/vicx_core_model.sv
`timescale 1ns/100ps
module vicx_core_model (
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  input  wire logic i_call_req,
  input  wire logic i_slow,
  output logic      o_call_ack = 1'b0
);
  int cnt = 0;
  always @(negedge i_clk_sys) begin
    if (i_srst || o_call_ack || !i_call_req) begin
      o_call_ack <= 1'b0;
      cnt <= 0;
    end else if (cnt >= (i_slow ? 3 : 0)) begin
      o_call_ack <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // vicx_core_model

// ===== bench/vicx_irq_ctrl_monitor.sv
`timescale 1ns/100ps
module vicx_irq_monitor import vicx_pkg::*; (
  input wire logic        i_clk_sys,
  input wire logic        i_srst,
  input wire logic        i_sfr_rd,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic [7:0]  o_sfr_rdata,
  input wire logic        i_call_ack,
  input wire logic        o_call_req,
  input wire logic [15:0] o_call_vector,
  input wire logic [1:0]  o_in_service,
  input wire logic        i_reti_done,
  input wire logic        i_lin_event,
  input wire logic        i_lin_flag_clear_ctl,
  input wire logic        o_lin_pending_flag,
  input wire logic [3:0]  o_auto_flags,
  input wire logic [3:0]  i_auto_flag_set
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  property p_rst; $past(i_srst) |-> !o_call_req && o_in_service == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
  property p_rd;
    !(i_sfr_rd && i_sfr_addr == IRQ_ENABLE_MAIN_ADDR) |=> o_sfr_rdata == 8'h00;
  endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  property p_ack; i_call_ack |=> !o_call_req && o_in_service != 2'h0;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not honoured");
  property p_reti; i_reti_done |=> !o_call_req; endproperty
  a_reti: assert property (p_reti) else $error("call right after return");
  property p_vec; o_call_req |-> o_call_vector[2:0] == 3'h3
    && o_call_vector[15:7] == 9'h000; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_hi; o_in_service[1] |-> !o_call_req; endproperty
  a_hi: assert property (p_hi) else $error("high handler preempted");
  property p_lin; o_lin_pending_flag && !i_lin_flag_clear_ctl
    |=> o_lin_pending_flag; endproperty
  a_lin: assert property (p_lin) else $error("LIN flag lost");
  property p_set; i_lin_event |=> o_lin_pending_flag; endproperty
  a_set: assert property (p_set) else $error("LIN flag not set");
  property p_auto; i_call_ack && o_call_vector < 16'h0020
    && i_auto_flag_set == 4'h0 |=> !o_auto_flags[$past(o_call_vector[4:3])];
  endproperty
  a_auto: assert property (p_auto) else $error("flag kept on vector");
endmodule // vicx_irq_monitor
bind vicx_irq_ctrl vicx_irq_monitor u_mon (.i_clk_sys(i_clk_sys),
  .i_srst(i_srst), .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr),
  .o_sfr_rdata(o_sfr_rdata), .i_call_ack(i_call_ack),
  .o_call_req(o_call_req), .o_call_vector(o_call_vector),
  .o_in_service(o_in_service), .i_reti_done(i_reti_done),
  .i_lin_event(i_lin_event), .i_lin_flag_clear_ctl(i_lin_flag_clear_ctl),
  .o_lin_pending_flag(o_lin_pending_flag), .o_auto_flags(o_auto_flags),
  .i_auto_flag_set(i_auto_flag_set));

// ===== design/vicx_arbiter.sv
`timescale 1ns/100ps
module vicx_arbiter (
  input  wire logic [7:0] i_active,
  input  wire logic [7:0] i_high,
  input  wire logic       i_srv_hi,
  input  wire logic       i_srv_lo,
  output logic            o_valid,
  output logic [2:0]      o_idx,
  output logic            o_level
);
  import vicx_pkg::*;

  logic       hit_hi;
  logic       hit_lo;
  logic [2:0] idx_hi;
  logic [2:0] idx_lo;

  always_comb begin
    hit_hi = 1'b0;
    hit_lo = 1'b0;
    idx_hi = 3'h0;
    idx_lo = 3'h0;
    // Descending scan so the lowest slot is left standing
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (i_active[i] && i_high[i]) begin
        hit_hi = 1'b1;
        idx_hi = 3'(i);
      end
      if (i_active[i] && !i_high[i]) begin
        hit_lo = 1'b1;
        idx_lo = 3'(i);
      end
    end
    o_valid = 1'b0;
    o_idx   = 3'h0;
    o_level = 1'b0;
    // R13 high preempts low
    if (hit_hi && !i_srv_hi) begin
      o_valid = 1'b1;
      o_idx   = idx_hi;
      o_level = 1'b1;
    // R5 equal level waits
    end else if (hit_lo && !i_srv_hi && !i_srv_lo) begin
      o_valid = 1'b1;
      o_idx   = idx_lo;
      o_level = 1'b0;
    end
  end

endmodule // vicx_arbiter

// ===== design/vicx_irq_ctrl.sv
`timescale 1ns/100ps
// Overview of operation
// R1: Sample all pending requests and arbitrate them every system clock.
// R2: Best case: one detect cycle, then the core's four-cycle call.
// R3: After a return, one more instruction completes before the next call.
// R4: Worst case eighteen clocks: detect, return, divide, then call.
// R5: Equal or higher level handler running blocks a new request.
// R6: Each source vectors to its own address, eight bytes apart, fixed order; the LIN slot vectors to 0x0073 instead of 0x003B.
// R7: LIN pending flag clears only through the LIN clear control.
// R8: Enable bit 7 gates all sources; at 1 each mask decides.
// R9: Enable bits 6..0 mask SPI, T2, UART, T1, ext1, T0, ext0.
// R10: Timer 2 mask admits either low or high byte overflow flag.
// R11: Enable register at 0xA8, any page, bit access, resets to zero.
// R12: External mask admits pin events; timer masks admit overflow flags.
// R13: High level preempts low, never preempted; fixed order breaks ties.
// R14: Pending flags set regardless of enable; disabled ones are ignored.
// R15: Flag still set after return raises a new request once the next instruction completes.
// R16: Ext and timer 0/1 flags self-clear on vectoring; others stay.
module vicx_irq_ctrl (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_srst,
  input  wire logic [7:0]           i_sfr_addr,
  input  wire logic                 i_sfr_wr,
  input  wire logic [7:0]           i_sfr_wdata,
  input  wire logic                 i_sfr_rd,
  input  wire logic                 i_sfr_bit_wr,
  input  wire logic [7:0]           i_sfr_bit_addr,
  input  wire logic                 i_sfr_bit_val,
  output logic [7:0]                o_sfr_rdata,
  input  wire logic                 i_ext_input_zero,
  input  wire logic                 i_ext_input_one,
  input  wire logic                 i_timer0_overflow_flag,
  input  wire logic                 i_timer1_overflow_flag,
  input  wire logic [vicx_pkg::NUM_AUTO-1:0] i_auto_flag_set,
  input  wire logic [vicx_pkg::NUM_AUTO-1:0] i_auto_flag_clr,
  output logic [vicx_pkg::NUM_AUTO-1:0]      o_auto_flags,
  input  wire logic                 i_uart_pending,
  input  wire logic                 i_timer2_low_overflow_flag,
  input  wire logic                 i_timer2_high_overflow_flag,
  input  wire logic                 i_spi_pending,
  input  wire logic                 i_lin_event,
  input  wire logic                 i_lin_flag_clear_ctl,
  input  wire logic                 i_lin_irq_en,
  output logic                      o_lin_pending_flag,
  input  wire logic [7:0]           i_slot_high_prio,
  input  wire logic                 i_instr_done,
  input  wire logic                 i_reti_done,
  input  wire logic                 i_call_ack,
  output logic                      o_call_req,
  output logic [15:0]               o_call_vector,
  output logic [1:0]                o_in_service
);
  import vicx_pkg::*;

  // Vector address of an arbitration slot
  function automatic logic [15:0] vec_of(input logic [2:0] slot);
    if (slot == SLOT_LIN) begin
      return VEC_LIN;
    end
    return VEC_FIRST + {10'h000, slot, 3'h0};
  endfunction

  // Enable register
  logic [7:0] enable_ff;
  logic [7:0] nxt_enable;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_enable = enable_ff;
    // R11 byte and bit access
    if (i_sfr_wr && i_sfr_addr == IRQ_ENABLE_MAIN_ADDR) begin
      nxt_enable = i_sfr_wdata;
    end else if (i_sfr_bit_wr &&
                 i_sfr_bit_addr[7:3] == IRQ_ENABLE_BIT_BLOCK) begin
      nxt_enable[i_sfr_bit_addr[2:0]] = i_sfr_bit_val;
    end
    nxt_rdata = 8'h00;
    if (i_sfr_rd && i_sfr_addr == IRQ_ENABLE_MAIN_ADDR) begin
      nxt_rdata = enable_ff;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      enable_ff <= IRQ_ENABLE_MAIN_RESET;
      rdata_ff  <= 8'h00;
    end else begin
      enable_ff <= nxt_enable;
      rdata_ff  <= nxt_rdata;
    end
  end

  // Pin synchronisers and falling-edge detect
  logic [1:0] pin_meta_ff;
  logic [1:0] pin_sync_ff;
  logic [1:0] pin_last_ff;
  logic [1:0] pin_fall;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pin_meta_ff <= 2'h3;
      pin_sync_ff <= 2'h3;
      pin_last_ff <= 2'h3;
    end else begin
      pin_meta_ff <= {i_ext_input_one, i_ext_input_zero};
      pin_sync_ff <= pin_meta_ff;
      pin_last_ff <= pin_sync_ff;
    end
  end

  assign pin_fall = pin_last_ff & ~pin_sync_ff;

  // Held pending flags and CPU handshake state
  logic [NUM_AUTO-1:0] auto_ff;
  logic [NUM_AUTO-1:0] nxt_auto;
  logic [NUM_AUTO-1:0] auto_evt;
  logic [NUM_AUTO-1:0] auto_ack_clr;
  logic                lin_ff;
  logic                nxt_lin;
  logic                hold_ff;
  logic                nxt_hold;
  logic [1:0]          srv_ff;
  logic [1:0]          nxt_srv;
  logic                req_ff;
  logic                nxt_req;
  logic [2:0]          slot_ff;
  logic [2:0]          nxt_slot;
  logic                level_ff;
  logic                nxt_level;
  logic [15:0]         vec_ff;
  logic [15:0]         nxt_vec;
  logic [7:0]          flag_vec;
  logic [7:0]          mask_vec;
  logic [7:0]          active;
  logic                arb_valid;
  logic [2:0]          arb_idx;
  logic                arb_level;

  // R12 pin events and overflow flags
  assign auto_evt = {i_timer1_overflow_flag, pin_fall[1],
                     i_timer0_overflow_flag, pin_fall[0]};

  // R10 either timer 2 flag
  assign flag_vec = {lin_ff, i_spi_pending,
                     i_timer2_low_overflow_flag | i_timer2_high_overflow_flag,
                     i_uart_pending, auto_ff};
  // R9 per-source masks
  assign mask_vec = {i_lin_irq_en, enable_ff[SERIAL_PERIPH_IRQ_MASK_POS:0]};
  // R8 global gate
  // R14 flags ignored when masked
  assign active = enable_ff[GLOBAL_IRQ_GATE_POS] ?
                  (flag_vec & mask_vec) : 8'h00;

  vicx_arbiter u_arbiter (
    .i_active (active),
    .i_high   (i_slot_high_prio),
    .i_srv_hi (srv_ff[1]),
    .i_srv_lo (srv_ff[0]),
    .o_valid  (arb_valid),
    .o_idx    (arb_idx),
    .o_level  (arb_level)
  );

  always_comb begin
    // R16 auto-clear on vectoring
    auto_ack_clr = '0;
    if (i_call_ack && slot_ff < SLOT_AUTO_END) begin
      auto_ack_clr[slot_ff[1:0]] = 1'b1;
    end
    // R14 set wins over clear
    nxt_auto = auto_evt | i_auto_flag_set |
               (auto_ff & ~(auto_ack_clr | i_auto_flag_clr));
    // R7 LIN flag clear control only
    nxt_lin = i_lin_event | (lin_ff & ~i_lin_flag_clear_ctl);
    // R3 one instruction after return
    // R4 hold spans next instruction
    nxt_hold = hold_ff;
    if (i_reti_done) begin
      nxt_hold = 1'b1;
    end else if (i_instr_done) begin
      nxt_hold = 1'b0;
    end
    // R13 in-service levels
    nxt_srv = srv_ff;
    if (i_reti_done) begin
      if (srv_ff[1]) begin
        nxt_srv[1] = 1'b0;
      end else begin
        nxt_srv[0] = 1'b0;
      end
    end
    if (i_call_ack) begin
      nxt_srv[level_ff] = 1'b1;
    end
    // R1 arbitrate every clock
    // R2 one detect cycle
    // R15 flag left set re-requests
    nxt_req   = arb_valid && !hold_ff && !i_reti_done && !i_call_ack;
    nxt_slot  = slot_ff;
    nxt_level = level_ff;
    nxt_vec   = vec_ff;
    if (arb_valid && !i_call_ack) begin
      nxt_slot  = arb_idx;
      nxt_level = arb_level;
      // R6 fixed vector per source
      nxt_vec   = vec_of(arb_idx);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      auto_ff  <= AUTO_FLAGS_RESET;
      lin_ff   <= 1'b0;
      hold_ff  <= 1'b0;
      srv_ff   <= IN_SERVICE_RESET;
      req_ff   <= 1'b0;
      slot_ff  <= 3'h0;
      level_ff <= 1'b0;
      vec_ff   <= VECTOR_RESET;
    end else begin
      auto_ff  <= nxt_auto;
      lin_ff   <= nxt_lin;
      hold_ff  <= nxt_hold;
      srv_ff   <= nxt_srv;
      req_ff   <= nxt_req;
      slot_ff  <= nxt_slot;
      level_ff <= nxt_level;
      vec_ff   <= nxt_vec;
    end
  end

  assign o_call_req         = req_ff;
  assign o_call_vector      = vec_ff;
  assign o_sfr_rdata        = rdata_ff;
  assign o_auto_flags       = auto_ff;
  assign o_lin_pending_flag = lin_ff;
  assign o_in_service       = srv_ff;

endmodule // vicx_irq_ctrl

// ===== design/vicx_pkg.sv
package vicx_pkg;

  // Register map
  localparam logic [7:0] IRQ_ENABLE_MAIN_ADDR  = 8'ha8;
  localparam logic [7:0] IRQ_ENABLE_MAIN_RESET = 8'h00;
  // Bit-address block of the enable register (byte address / 8)
  localparam logic [4:0] IRQ_ENABLE_BIT_BLOCK  = 5'h15;

  // Field positions in irq_enable_main
  localparam int GLOBAL_IRQ_GATE_POS        = 7;
  localparam int SERIAL_PERIPH_IRQ_MASK_POS = 6;
  localparam int TIMER2_IRQ_MASK_POS        = 5;
  localparam int UART_IRQ_MASK_POS          = 4;
  localparam int TIMER1_IRQ_MASK_POS        = 3;
  localparam int EXT_INPUT1_IRQ_MASK_POS    = 2;
  localparam int TIMER0_IRQ_MASK_POS        = 1;
  localparam int EXT_INPUT0_IRQ_MASK_POS    = 0;

  // Arbitration slots, in fixed order; slot 7 carries the LIN source
  localparam int          NUM_SLOTS     = 8;
  localparam int          NUM_AUTO      = 4;
  localparam logic [2:0]  SLOT_LIN      = 3'h7;
  localparam logic [2:0]  SLOT_AUTO_END = 3'h4;

  // Vector addresses
  localparam logic [15:0] VEC_FIRST = 16'h0003;
  localparam logic [15:0] VEC_LIN   = 16'h0073;

  // Reset values of held state
  localparam logic [3:0]  AUTO_FLAGS_RESET = 4'h0;
  localparam logic [1:0]  IN_SERVICE_RESET = 2'h0;
  localparam logic [15:0] VECTOR_RESET     = 16'h0000;

endpackage : vicx_pkg
